// ### rtl/macrocell_map.vh
`ifndef MACROCELL_MAP_VH
`define MACROCELL_MAP_VH

// Cell counts
`define N_OUT          16
`define N_BURIED       8
`define N_PAGE         3
`define N_CELL         27

// Register offsets (byte addresses)
`define ADDR_MODE      8'h00
`define ADDR_INV_A     8'h04
`define ADDR_INV_B     8'h08
`define ADDR_OUT_POL   8'h0c
`define ADDR_OE_SEL    8'h10
`define ADDR_STATE     8'h14
`define ADDR_PAGE      8'h18

// Reset values
`define RST_MODE       27'h0000000
`define RST_INV        27'h0000000
`define RST_OUT_POL    16'h0000
`define RST_OE_SEL     32'hffffffff

// Output enable select codes
`define OE_SEL_TERM0   2'h0
`define OE_SEL_TERM1   2'h1
`define OE_SEL_TERM2   2'h2
`define OE_SEL_PIN     2'h3

// Field positions in the page register
`define PAGE_LSB       0
`define PAGE_MSB       2
`define PAGE_PIN_BIT   3

`endif

// ### rtl/macrocell_reg.v
`timescale 1ns/10ps
`default_nettype none

module macrocell_reg
(
  input  wire ref_clk,
  input  wire ce,
  input  wire glb_clr,
  input  wire data_with_enable_mode,
  input  wire inv_a,
  input  wire inv_b,
  input  wire a_term,
  input  wire b_term,
  output reg  state_q
);

  wire set_in;
  wire clr_in;
  reg  state_d;

  assign set_in = a_term ^ inv_a;
  assign clr_in = b_term ^ inv_b;

  always @*
  begin
    state_d = state_q;
    if (data_with_enable_mode)
    begin
      if (clr_in)
        state_d = set_in;
    end
    else
    begin
      case ({set_in, clr_in})
        2'h1:    state_d = 1'b0;
        2'h2:    state_d = 1'b1;
        2'h3:    state_d = ~state_q;
        default: state_d = state_q;
      endcase
    end
  end

  // Clear is a term of the array, not a pin, so it acts without the clock
  always @(posedge ref_clk or posedge glb_clr)
  begin
    if (glb_clr)
      state_q <= 1'b0;
    else if (ce)
      state_q <= state_d;
  end

endmodule // macrocell_reg

`default_nettype wire

// ### rtl/oe_select.v
`timescale 1ns/10ps
`default_nettype none

`include "macrocell_map.vh"

module oe_select
(
  input  wire [1:0] sel,
  input  wire [2:0] oe_terms,
  input  wire       oe_pin_n_sync,
  output reg        enable
);

  always @*
  begin
    case (sel)
      `OE_SEL_TERM0: enable = oe_terms[0];
      `OE_SEL_TERM1: enable = oe_terms[1];
      `OE_SEL_TERM2: enable = oe_terms[2];
      default:       enable = ~oe_pin_n_sync;
    endcase
  end

endmodule // oe_select

`default_nettype wire

// ### rtl/macrocell_array.v
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none

`include "macrocell_map.vh"

module macrocell_array
(
  input  wire        ref_clk,
  input  wire        rstn,
  input  wire        ce,
  input  wire        glb_clr,
  input  wire [26:0] a_terms,
  input  wire [26:0] b_terms,
  input  wire [2:0]  oe_terms,
  input  wire        oe_pin_n,
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  output wire [15:0] out_pin_o,
  output wire [15:0] out_pin_oe,
  output wire [15:0] io_fb,
  output wire [7:0]  buried_q,
  output wire [2:0]  page_sel,
  output wire [7:0]  page_active
);

  reg  [26:0] mode_q;
  reg  [26:0] inv_a_q;
  reg  [26:0] inv_b_q;
  reg  [15:0] out_pol_q;
  reg  [31:0] oe_sel_q;
  reg         oe_pin_meta_q;
  reg         oe_pin_sync_q;
  reg  [31:0] rdata_d;
  wire [26:0] cell_q;
  wire [15:0] oe_raw;
  reg  [15:0] pin_q;
  reg  [15:0] pin_oe_q;

  // Config registers; reset is synchronous and acts regardless of the enable; writes need ce
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      mode_q    <= `RST_MODE;
      inv_a_q   <= `RST_INV;
      inv_b_q   <= `RST_INV;
      out_pol_q <= `RST_OUT_POL;
      oe_sel_q  <= `RST_OE_SEL;
    end
    else if (ce && wr)
    begin
      case (addr)
        `ADDR_MODE:    mode_q    <= wdata[26:0];
        `ADDR_INV_A:   inv_a_q   <= wdata[26:0];
        `ADDR_INV_B:   inv_b_q   <= wdata[26:0];
        `ADDR_OUT_POL: out_pol_q <= wdata[15:0];
        `ADDR_OE_SEL:  oe_sel_q  <= wdata;
        default:       mode_q    <= mode_q;
      endcase
    end
  end

  // Pin comes from outside the clock domain: two flops before use
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      oe_pin_meta_q <= 1'b1;
      oe_pin_sync_q <= 1'b1;
    end
    else if (ce)
    begin
      oe_pin_meta_q <= oe_pin_n;
      oe_pin_sync_q <= oe_pin_meta_q;
    end
  end

  always @*
  begin
    rdata_d = 32'h00000000;
    case (addr)
      `ADDR_MODE:    rdata_d = {5'h00, mode_q};
      `ADDR_INV_A:   rdata_d = {5'h00, inv_a_q};
      `ADDR_INV_B:   rdata_d = {5'h00, inv_b_q};
      `ADDR_OUT_POL: rdata_d = {16'h0000, out_pol_q};
      `ADDR_OE_SEL:  rdata_d = oe_sel_q;
      `ADDR_STATE:   rdata_d = {5'h00, cell_q};
      `ADDR_PAGE:    rdata_d = {28'h0000000, oe_pin_sync_q, cell_q[26:24]};
      default:       rdata_d = 32'h00000000;
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (!rstn)
      rdata <= 32'h00000000;
    else if (ce)
      rdata <= rd ? rdata_d : 32'h00000000;
  end

  // Cells 0..15 output, 16..23 buried, 24..26 page; all the same cell
  genvar i;
  generate
    for (i = 0; i < `N_CELL; i = i + 1)
    begin : g_cell
      macrocell_reg u_cell
      (
        .ref_clk               (ref_clk),
        .ce                    (ce),
        .glb_clr               (glb_clr),
        .data_with_enable_mode (mode_q[i]),
        .inv_a                 (inv_a_q[i]),
        .inv_b                 (inv_b_q[i]),
        .a_term                (a_terms[i]),
        .b_term                (b_terms[i]),
        .state_q               (cell_q[i])
      );
    end
    for (i = 0; i < `N_OUT; i = i + 1)
    begin : g_oe
      oe_select u_oe
      (
        .sel           (oe_sel_q[2*i+1:2*i]),
        .oe_terms      (oe_terms),
        .oe_pin_n_sync (oe_pin_sync_q),
        .enable        (oe_raw[i])
      );
    end
  endgenerate

  // Pin data and enable registered so data outputs come from flops;
  // costs one cycle of pin latency against the cell state
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      pin_q    <= 16'h0000;
      pin_oe_q <= 16'h0000;
    end
    else if (ce)
    begin
      pin_q    <= cell_q[15:0] ^ out_pol_q;
      pin_oe_q <= oe_raw;
    end
  end

  assign out_pin_o  = pin_q;
  assign out_pin_oe = pin_oe_q;
  assign io_fb      = cell_q[15:0] ^ out_pol_q;
  assign buried_q   = cell_q[23:16];
  assign page_sel   = cell_q[26:24];
  assign page_active = 8'h01 << page_sel;

endmodule // macrocell_array

`default_nettype wire

// ### sim/macrocell_array_sva.sv
`timescale 1ns/10ps
`default_nettype none
module macrocell_array_chk
(
  input wire        ref_clk,
  input wire        rstn,
  input wire        ce,
  input wire        glb_clr,
  input wire [2:0]  oe_terms,
  input wire        oe_pin_n,
  input wire [15:0] out_pin_o,
  input wire [15:0] out_pin_oe,
  input wire [15:0] io_fb,
  input wire [7:0]  buried_q,
  input wire [2:0]  page_sel,
  input wire [7:0]  page_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence clr_idle;
    glb_clr ##1 !ce [*2];
  endsequence
  // Pin path needs three enabled edges (two sync stages plus the output flop); the check samples on the fourth
  sequence all_on;
    (ce && oe_terms == 3'h7 && !oe_pin_n) [*4];
  endsequence
  sequence all_off;
    (ce && oe_terms == 3'h0 && oe_pin_n) [*4];
  endsequence
  pin_follow_a: assert property ($past(ce) && $past(rstn) |-> out_pin_o == $past(io_fb))
    else $error("pin data differs from feedback");
  clr_cells_a: assert property (glb_clr |-> buried_q == 8'h0 && page_sel == 3'h0)
    else $error("cells not cleared");
  page_onehot_a: assert property (page_active == 8'h01 << page_sel)
    else $error("page decode wrong");
  freeze_a: assert property (!ce && !glb_clr |=> glb_clr || $stable({io_fb, buried_q, page_sel}))
    else $error("cells moved without enable");
  clr_hold_a: assert property (clr_idle |=> buried_q == 8'h0 && page_sel == 3'h0)
    else $error("cleared cells did not hold");
  oe_on_a: assert property (all_on |-> out_pin_oe == 16'hffff)
    else $error("outputs not enabled");
  oe_off_a: assert property (all_off |-> out_pin_oe == 16'h0)
    else $error("outputs not disabled");
  cell_edge_a: assert property (!$stable(buried_q) |-> $past(ce) || glb_clr || $past(glb_clr))
    else $error("cell changed off an enabled edge");
endmodule // macrocell_array_chk
bind macrocell_array macrocell_array_chk chk_i (.ref_clk, .rstn, .ce, .glb_clr, .oe_terms, .oe_pin_n,
  .out_pin_o, .out_pin_oe, .io_fb, .buried_q, .page_sel, .page_active);
`default_nettype wire

// ### sim/board_oe_driver.sv
`timescale 1ns/10ps
`default_nettype none
module board_oe_driver
(
  input  wire logic ref_clk,
  input  wire logic oe_req,
  output var logic  oe_pin_n
);
  // Pin moves 7 ns after each rising edge of the device clock, clear of the sampling edge
  initial oe_pin_n = 1'b1;
  always @(posedge ref_clk)
    oe_pin_n <= #7 ~oe_req;
endmodule // board_oe_driver
`default_nettype wire

// ### sim/test_programmable_register_macrocell.sv
`timescale 1ns/10ps
`default_nettype none
`include "macrocell_map.vh"
module test_programmable_register_macrocell;
  localparam logic [26:0] t1 = 27'h7ffffff;
  localparam logic [31:0] st1 = 32'h7ffffff;
  logic        ref_clk, rstn = 1'b0, ce = 1'b1, glb_clr = 1'b1, wr = 1'b0, rd = 1'b0, oe_req = 1'b0;
  logic [26:0] a_terms = '0, b_terms = '0;
  logic [2:0]  oe_terms = '0;
  logic [7:0]  addr = '0;
  logic [31:0] wdata = '0;
  wire         oe_pin_n;
  wire  [31:0] rdata;
  wire  [15:0] out_pin_o, out_pin_oe, io_fb;
  wire  [7:0]  buried_q, page_active;
  wire  [2:0]  page_sel;
  int          miscompares, n_checks, cyc_n;
  macrocell_array uut
  (
    .ref_clk, .rstn, .ce, .glb_clr, .a_terms, .b_terms, .oe_terms, .oe_pin_n, .addr, .wdata, .wr, .rd,
    .rdata, .out_pin_o, .out_pin_oe, .io_fb, .buried_q, .page_sel, .page_active
  );
  board_oe_driver board (.ref_clk, .oe_req, .oe_pin_n);
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic results;
    if (miscompares == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, s);
    n_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  // Terms return to idle after one edge so reads see a settled state
  task automatic step(input logic [26:0] a, b);
    @(posedge ref_clk);
    a_terms <= a;
    b_terms <= b;
    @(posedge ref_clk);
    a_terms <= '0;
    b_terms <= '0;
  endtask
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    glb_clr <= 1'b0;
    rchk(`ADDR_STATE, 32'h0);
    rchk(`ADDR_OE_SEL, 32'hffffffff);
    rchk(8'hfc, 32'h0);
    step(t1, '0);
    rchk(`ADDR_STATE, st1);
    step(t1, t1);
    rchk(`ADDR_STATE, 32'h0);
    step(t1, '0);
    repeat (2) step('0, t1);
    rchk(`ADDR_STATE, 32'h0);
    wreg(`ADDR_INV_A, st1);
    rchk(`ADDR_STATE, st1);
    wreg(`ADDR_INV_A, 32'h0);
    wreg(`ADDR_MODE, st1);
    step('0, t1);
    rchk(`ADDR_STATE, 32'h0);
    step(t1, '0);
    rchk(`ADDR_STATE, 32'h0);
    wreg(`ADDR_INV_B, st1);
    wreg(`ADDR_INV_A, st1);
    rchk(`ADDR_STATE, st1);
    @(posedge ref_clk);
    #5 glb_clr <= 1'b1;
    #1 chk("buried_q", 32'h0, {24'h0, buried_q});
    @(posedge ref_clk);
    glb_clr <= 1'b0;
    ce <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk("page_sel", 32'h0, {29'h0, page_sel});
    ce <= 1'b1;
    @(posedge ref_clk);
    #1 chk("page_active", 32'h80, {24'h0, page_active});
    rchk(`ADDR_PAGE, 32'hf);
    wreg(`ADDR_OUT_POL, 32'hffff);
    @(posedge ref_clk);
    #1 chk("pin", 32'h0, {io_fb, out_pin_o});
    rchk(`ADDR_OUT_POL, 32'hffff);
    for (int k = 0; k < 4; k++)
    begin
      wreg(`ADDR_OE_SEL, {16{k[1:0]}});
      @(posedge ref_clk);
      oe_terms <= (k == 3) ? 3'h7 : 3'h1 << k;
      oe_req <= (k == 3);
      repeat (5) @(posedge ref_clk);
      #1 chk("oe_on", 32'hffff, {16'h0, out_pin_oe});
      oe_terms <= (k == 3) ? 3'h0 : ~(3'h1 << k);
      oe_req <= (k != 3);
      repeat (5) @(posedge ref_clk);
      #1 chk("oe_off", 32'h0, {16'h0, out_pin_oe});
    end
    results;
  end
  always @(posedge ref_clk)
  begin
    cyc_n++;
    if (cyc_n == 2000)
    begin
      miscompares++;
      results;
    end
  end
endmodule // test_programmable_register_macrocell
`default_nettype wire
